// ### design/i2c_bit_engine.sv
/*
  Bit engine: Start, Stop and 9-bit byte slots on the two-wire bus.
  Assumes line inputs are already synchronised to mclk_in; after a byte
  it leaves the serial clock low until the next command.
*/
`timescale 1ns/10ps
`include "i2c_seq_map.svh"
module i2c_bit_engine
  import i2c_seq_pkg::*;
#(
  parameter int QTR_CYC = `I2C_QTR_CYC,
  parameter int CW      = `I2C_TICK_W
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // Command
  input  wire logic       cmd_valid_in,
  input  wire eng_cmd_t   cmd_in,
  output logic            done_out,
  output logic [7:0]      rx_byte_out,
  output logic            ack_rcvd_out,
  // Bus lines
  input  wire line_t      line_in,
  output logic            scl_low_out,
  output logic            sda_low_out
);

  eng_state_t st_q, st_d;
  logic [CW-1:0] tick_q, tick_d;
  logic [1:0] qtr_q, qtr_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  eng_op_t op_q, op_d;
  logic acken_q, acken_d, scl_q, scl_d, sda_q, sda_d, done_q, done_d, ack_q, ack_d;
  logic tick_end, stall;
  logic [3:0] nb;

  always_comb begin
    st_d    = st_q;
    tick_d  = tick_q;
    qtr_d   = qtr_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    op_d    = op_q;
    acken_d = acken_q;
    scl_d   = scl_q;
    sda_d   = sda_q;
    ack_d   = ack_q;
    done_d  = 1'b0;
    tick_end = (tick_q == CW'(QTR_CYC - 1));
    // A slave may stretch the clock: wait while released clock reads low
    stall = !scl_q && !line_in.scl;
    nb = bit_q + 4'h1;
    if (st_q == E_IDLE) begin
      if (cmd_valid_in) begin
        op_d    = cmd_in.op;
        sh_d    = cmd_in.data;
        acken_d = cmd_in.ack_en;
        tick_d  = '0;
        qtr_d   = 2'h0;
        bit_d   = 4'h0;
        unique case (cmd_in.op)
          OP_START: begin
            st_d  = E_START;
            sda_d = 1'b0;
          end
          OP_STOP: begin
            st_d  = E_STOP;
            sda_d = 1'b1;
          end
          default: begin
            st_d  = E_BIT;
            sda_d = (cmd_in.op == OP_WRITE) && !cmd_in.data[7];
          end
        endcase
      end
    end else if (!stall) begin
      tick_d = tick_end ? '0 : tick_q + CW'(1);
      if (tick_end) begin
        qtr_d = qtr_q + 2'h1;
        unique case (st_q)
          E_START: begin
            if (qtr_q == 2'h0) scl_d = 1'b0;
            if (qtr_q == 2'h1) sda_d = 1'b1;
            if (qtr_q == 2'h2) begin
              scl_d  = 1'b1;
              done_d = 1'b1;
              st_d   = E_IDLE;
            end
          end
          E_STOP: begin
            if (qtr_q == 2'h0) scl_d = 1'b0;
            if (qtr_q == 2'h1) sda_d = 1'b0;
            if (qtr_q == 2'h2) begin
              done_d = 1'b1;
              st_d   = E_IDLE;
            end
          end
          default: begin
            if (qtr_q == 2'h0) scl_d = 1'b0;
            if (qtr_q == 2'h2) begin
              if (bit_q == `I2C_LAST_BIT) ack_d = !line_in.sda;
              else sh_d = {sh_q[6:0], line_in.sda};
            end
            if (qtr_q == 2'h3) begin
              scl_d = 1'b1;
              if (bit_q == `I2C_LAST_BIT) begin
                done_d = 1'b1;
                st_d   = E_IDLE;
                sda_d  = 1'b0;
              end else begin
                bit_d = nb;
                sda_d = (nb == `I2C_LAST_BIT) ? (op_q == OP_READ && acken_q)
                                              : (op_q == OP_WRITE && !sh_q[7]);
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q    <= E_IDLE;
      tick_q  <= '0;
      qtr_q   <= 2'h0;
      bit_q   <= 4'h0;
      sh_q    <= `I2C_BYTE_RST;
      op_q    <= OP_START;
      acken_q <= 1'b0;
      scl_q   <= 1'b0;
      sda_q   <= 1'b0;
      done_q  <= 1'b0;
      ack_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      tick_q  <= tick_d;
      qtr_q   <= qtr_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      op_q    <= op_d;
      acken_q <= acken_d;
      scl_q   <= scl_d;
      sda_q   <= sda_d;
      done_q  <= done_d;
      ack_q   <= ack_d;
    end
  end

  assign done_out     = done_q;
  assign rx_byte_out  = sh_q;
  assign ack_rcvd_out = ack_q;
  assign scl_low_out  = scl_q;
  assign sda_low_out  = sda_q;

endmodule

// ### design/i2c_master_sequencer.sv
/*
  Master-mode sequencer of a two-wire bus controller: Start, 7/10-bit
  addressing, master reception, Stop and line release.
  Assumes software accesses arrive as one-cycle strobes on mclk_in and
  that the bus pins are open drain, resolved outside.
*/
// What this block does
// [RULE_01] Slave after reset; master only via Start
// [RULE_02] Start request on idle bus starts master
// [RULE_03] Start sent sets event and start flags
// [RULE_04] Hold clock until status read, address write
// [RULE_05] 7-bit mode shifts one address byte
// [RULE_06] 10-bit header: event, stretch, second byte
// [RULE_07] Address done: event, stretch until control write
// [RULE_08] 10-bit read: repeated Start, header low bit set
// [RULE_09] Received byte: ack, event, byte done flags
// [RULE_10] Stretch until status read, data read
// [RULE_11] Software requests Stop before last read
// [RULE_12] After Stop return to slave, clear master
// [RULE_13] Software clears acknowledge before second-last read
// [RULE_14] Stop pulse during byte done releases lines
// [RULE_15] Access without prior status read keeps stretching
`timescale 1ns/10ps
`include "i2c_seq_map.svh"
module i2c_master_sequencer
  import i2c_seq_pkg::*;
#(
  parameter int QTR_CYC = `I2C_QTR_CYC
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // Control bits
  input  wire logic       interface_on_bit_in,
  input  wire logic       interrupt_enable_bit_in,
  input  wire logic       ack_enable_in,
  input  wire logic       start_req_in,
  input  wire logic       stop_req_in,
  // Software access strobes
  input  wire logic       status_read_in,
  input  wire logic       data_write_in,
  input  wire logic [7:0] data_wdata_in,
  input  wire logic       data_read_in,
  input  wire logic       control_write_in,
  // Status
  output logic            master_select_flag_out,
  output logic            event_flag_out,
  output logic            start_sent_flag_out,
  output logic            byte_done_flag_out,
  output logic            addr_nack_flag_out,
  output logic            bus_busy_out,
  output logic            irq_out,
  output logic [7:0]      data_register_out,
  // Bus pins, enable low while driving low
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n_out,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out
);

  line_t sync1_q, sync2_q, prev_q;
  logic busy_q, busy_d;
  logic start_det, stop_det;

  seq_state_t st_q, st_d;
  logic ms_q, ms_d, evf_q, evf_d, sb_q, sb_d, btf_q, btf_d, nack_q, nack_d;
  logic seen_q, seen_d, hdr10_q, hdr10_d, rx_q, rx_d, stopl_q, stopl_d;
  logic start_prev_q, stop_prev_q, irq_q, irq_d;
  logic [7:0] dr_q, dr_d;
  logic cmd_valid_q, cmd_valid_d;
  eng_cmd_t cmd_q, cmd_d;
  logic start_rise, stop_fall;

  logic eng_done, eng_ack, eng_scl_low, eng_sda_low;
  logic [7:0] eng_rx;

  // Pin synchronisers; edge detection reads only the second stage onward
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= '{sda: 1'b1, scl: 1'b1};
      sync2_q <= '{sda: 1'b1, scl: 1'b1};
      prev_q  <= '{sda: 1'b1, scl: 1'b1};
    end else begin
      sync1_q <= '{sda: sda_in, scl: scl_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Bus busy from Start and Stop seen on the lines
  always_comb begin
    start_det = prev_q.sda && !sync2_q.sda && sync2_q.scl;
    stop_det  = !prev_q.sda && sync2_q.sda && sync2_q.scl;
    busy_d = busy_q;
    if (stop_det) busy_d = 1'b0;
    if (start_det) busy_d = 1'b1;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) busy_q <= 1'b0;
    else busy_q <= busy_d;
  end

  // Sequencer
  always_comb begin
    st_d        = st_q;
    ms_d        = ms_q;
    evf_d       = evf_q;
    sb_d        = sb_q;
    btf_d       = btf_q;
    nack_d      = nack_q;
    seen_d      = seen_q;
    hdr10_d     = hdr10_q;
    rx_d        = rx_q;
    stopl_d     = stopl_q;
    dr_d        = dr_q;
    cmd_d       = cmd_q;
    cmd_valid_d = 1'b0;
    start_rise = start_req_in && !start_prev_q;
    stop_fall  = !stop_req_in && stop_prev_q;

    // Status read arms the following data or control access
    if (status_read_in && evf_q) seen_d = 1'b1; // RULE_15
    if (stop_fall && btf_q) stopl_d = 1'b1; // RULE_14

    unique case (st_q)
      S_SLAVE: begin
        ms_d = 1'b0; // RULE_01
        if (start_rise && !busy_q && interface_on_bit_in) begin
          ms_d = 1'b1; // RULE_02
          cmd_d = '{op: OP_START, data: dr_q, ack_en: 1'b0};
          cmd_valid_d = 1'b1;
          st_d = S_START;
        end
      end
      S_START: begin
        if (eng_done) begin
          evf_d = 1'b1; // RULE_03
          sb_d  = 1'b1;
          st_d  = S_EV5;
        end
      end
      S_EV5: begin
        // Clock stays low until the address write follows a status read
        if (data_write_in && seen_q) begin // RULE_04
          seen_d = 1'b0;
          evf_d = 1'b0;
          sb_d = 1'b0;
          dr_d = data_wdata_in;
          hdr10_d = (data_wdata_in[7:3] == `I2C_HDR10) && !data_wdata_in[0];
          // A header with read bit after repeated Start goes straight to EV6
          rx_d = data_wdata_in[0]; // RULE_08
          cmd_d = '{op: OP_WRITE, data: data_wdata_in, ack_en: 1'b0}; // RULE_05
          cmd_valid_d = 1'b1;
          st_d = S_ADDR;
        end
      end
      S_ADDR: begin
        if (eng_done) begin
          evf_d = 1'b1; // RULE_06
          nack_d = ack_enable_in && !eng_ack;
          st_d = hdr10_q ? S_EV9 : S_EV6; // RULE_05
        end
      end
      S_EV9: begin
        if (data_write_in && seen_q) begin // RULE_06
          seen_d = 1'b0;
          evf_d = 1'b0;
          dr_d = data_wdata_in;
          cmd_d = '{op: OP_WRITE, data: data_wdata_in, ack_en: 1'b0};
          cmd_valid_d = 1'b1;
          st_d = S_ADDR2;
        end
      end
      S_ADDR2: begin
        if (eng_done) begin
          evf_d = 1'b1; // RULE_07
          nack_d = ack_enable_in && !eng_ack;
          st_d = S_EV6;
        end
      end
      S_EV6: begin
        if (control_write_in && seen_q) begin // RULE_07
          seen_d = 1'b0;
          evf_d = 1'b0;
          if (rx_q) begin
            cmd_d = '{op: OP_READ, data: dr_q, ack_en: ack_enable_in};
            cmd_valid_d = 1'b1;
            st_d = S_RX;
          end else begin
            st_d = S_HOLD;
          end
        end
      end
      S_HOLD: begin
        if (start_rise) begin
          cmd_d = '{op: OP_START, data: dr_q, ack_en: 1'b0};
          cmd_valid_d = 1'b1;
          st_d = S_START;
        end else if (stop_req_in || stopl_q) begin
          cmd_d = '{op: OP_STOP, data: dr_q, ack_en: 1'b0};
          cmd_valid_d = 1'b1;
          st_d = S_STOP;
        end
      end
      S_RX: begin
        if (eng_done) begin
          dr_d = eng_rx;
          evf_d = 1'b1; // RULE_09
          btf_d = 1'b1;
          st_d = S_EV7;
        end
      end
      S_EV7: begin
        if (stopl_q) begin
          evf_d = 1'b0;
          btf_d = 1'b0;
          seen_d = 1'b0;
          cmd_d = '{op: OP_STOP, data: dr_q, ack_en: 1'b0}; // RULE_14
          cmd_valid_d = 1'b1;
          st_d = S_STOP;
        end else if (data_read_in && seen_q) begin // RULE_10
          seen_d = 1'b0;
          evf_d = 1'b0;
          btf_d = 1'b0;
          if (stop_req_in) begin
            cmd_d = '{op: OP_STOP, data: dr_q, ack_en: 1'b0}; // RULE_11
            st_d = S_STOP;
          end else if (start_req_in) begin
            cmd_d = '{op: OP_START, data: dr_q, ack_en: 1'b0};
            st_d = S_START;
          end else begin
            // Acknowledge setting is taken per byte, so a late clear still acks the byte in progress
            cmd_d = '{op: OP_READ, data: dr_q, ack_en: ack_enable_in}; // RULE_13
            st_d = S_RX;
          end
          cmd_valid_d = 1'b1;
        end
      end
      S_STOP: begin
        if (eng_done) begin
          ms_d = 1'b0; // RULE_12
          stopl_d = 1'b0;
          st_d = S_SLAVE;
        end
      end
      default: st_d = S_SLAVE;
    endcase
    irq_d = interrupt_enable_bit_in && evf_d; // RULE_03
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q         <= S_SLAVE;
      ms_q         <= 1'b0;
      evf_q        <= 1'b0;
      sb_q         <= 1'b0;
      btf_q        <= 1'b0;
      nack_q       <= 1'b0;
      seen_q       <= 1'b0;
      hdr10_q      <= 1'b0;
      rx_q         <= 1'b0;
      stopl_q      <= 1'b0;
      start_prev_q <= 1'b0;
      stop_prev_q  <= 1'b0;
      irq_q        <= 1'b0;
      dr_q         <= `I2C_BYTE_RST;
      cmd_valid_q <= 1'b0;
      cmd_q <= '{op: OP_START, data: `I2C_BYTE_RST, ack_en: 1'b0};
    end else begin
      st_q         <= st_d;
      ms_q         <= ms_d;
      evf_q        <= evf_d;
      sb_q         <= sb_d;
      btf_q        <= btf_d;
      nack_q       <= nack_d;
      seen_q       <= seen_d;
      hdr10_q      <= hdr10_d;
      rx_q         <= rx_d;
      stopl_q      <= stopl_d;
      start_prev_q <= start_req_in;
      stop_prev_q  <= stop_req_in;
      irq_q        <= irq_d;
      dr_q         <= dr_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_q <= cmd_d;
    end
  end

  i2c_bit_engine #(
    .QTR_CYC (QTR_CYC),
    .CW      (`I2C_TICK_W)
  ) i2c_bit_engine_i (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .cmd_valid_in (cmd_valid_q),
    .cmd_in       (cmd_q),
    .done_out     (eng_done),
    .rx_byte_out  (eng_rx),
    .ack_rcvd_out (eng_ack),
    .line_in      (sync2_q),
    .scl_low_out  (eng_scl_low),
    .sda_low_out  (eng_sda_low)
  );

  assign master_select_flag_out = ms_q;
  assign event_flag_out         = evf_q;
  assign start_sent_flag_out    = sb_q;
  assign byte_done_flag_out     = btf_q;
  assign addr_nack_flag_out     = nack_q;
  assign bus_busy_out           = busy_q;
  assign irq_out                = irq_q;
  assign data_register_out      = dr_q;
  assign scl_out                = 1'b0;
  assign sda_out                = 1'b0;
  // Engine holds the clock low between bytes, which is the stretch
  assign scl_oe_n_out           = !eng_scl_low; // RULE_04
  assign sda_oe_n_out           = !eng_sda_low;

endmodule

// ### design/i2c_seq_map.svh
/*
  Constants of the two-wire master sequencer: timing and address codes.
  Assumes the block clock runs at 125 MHz.
*/
`ifndef I2C_SEQ_MAP_SVH
`define I2C_SEQ_MAP_SVH

`define I2C_MCLK_NS     8
`define I2C_SCL_QTR_NS  2500
`define I2C_QTR_CYC     ((`I2C_SCL_QTR_NS + `I2C_MCLK_NS - 1) / `I2C_MCLK_NS)
`define I2C_TICK_W      12
`define I2C_HDR10       5'h1e
`define I2C_LAST_BIT    4'h8
`define I2C_BYTE_RST    8'h00

`endif

// ### design/i2c_seq_pkg.sv
/*
  Types shared by the sequencer and its bit engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package i2c_seq_pkg;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} eng_op_t;

  typedef struct packed {
    eng_op_t    op;
    logic [7:0] data;
    logic       ack_en;
  } eng_cmd_t;

  typedef struct packed {
    logic sda;
    logic scl;
  } line_t;

  typedef enum logic [1:0] {E_IDLE, E_START, E_STOP, E_BIT} eng_state_t;

  typedef enum logic [3:0] {
    S_SLAVE, S_START, S_EV5, S_ADDR, S_EV9, S_ADDR2,
    S_EV6, S_HOLD, S_RX, S_EV7, S_STOP
  } seq_state_t;

endpackage

// ### sim/i2c_master_sequencer_props.sv
/* Checker of the master sequencer ports.
   Assumes it is bound to each sequencer instance. */
`timescale 1ns/10ps
module i2c_master_sequencer_props #(
  parameter int QTR_CYC = 4
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic interface_on_bit_in,
  input wire logic interrupt_enable_bit_in,
  input wire logic start_req_in,
  input wire logic stop_req_in,
  input wire logic status_read_in,
  input wire logic data_write_in,
  input wire logic data_read_in,
  input wire logic control_write_in,
  input wire logic master_select_flag_out,
  input wire logic event_flag_out,
  input wire logic start_sent_flag_out,
  input wire logic byte_done_flag_out,
  input wire logic bus_busy_out,
  input wire logic irq_out,
  input wire logic scl_oe_n_out,
  input wire logic sda_oe_n_out
);
  logic sr_seen_q;
  logic sr_seen_d;
  // Status read seen during the current wait
  always_comb sr_seen_d = event_flag_out & (sr_seen_q | status_read_in);
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in) sr_seen_q <= 1'b0;
    else sr_seen_q <= sr_seen_d;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  chk_master_cause:
  assert property ($rose(master_select_flag_out) |-> $past(start_req_in)
    || $past(start_req_in, 2)) else $error("master mode without start request");
  chk_start_take:
  assert property ($rose(start_req_in) && interface_on_bit_in && !bus_busy_out
    && !master_select_flag_out && !event_flag_out |-> ##[1:2] master_select_flag_out)
    else $error("start request not taken");
  chk_start_flags:
  assert property ($rose(start_sent_flag_out) |-> event_flag_out
    && master_select_flag_out) else $error("start flag without event");
  chk_irq_level:
  assert property (irq_out == ($past(interrupt_enable_bit_in) && event_flag_out))
    else $error("irq does not follow event and enable");
  chk_stretch_hold:
  assert property (event_flag_out && master_select_flag_out |-> !scl_oe_n_out)
    else $error("clock not held low while waiting");
  chk_bare_access:
  assert property (event_flag_out && !sr_seen_q && (data_write_in || data_read_in
    || control_write_in) |=> event_flag_out) else $error("access taken without status read");
  chk_done_stands:
  assert property (byte_done_flag_out && !data_read_in && !stop_req_in
    && !$past(stop_req_in) && !$past(stop_req_in, 2) |=> byte_done_flag_out)
    else $error("byte done dropped without data read");
  chk_stop_release:
  assert property ($fell(master_select_flag_out) |-> scl_oe_n_out && sda_oe_n_out)
    else $error("master left with lines held");
endmodule
bind i2c_master_sequencer i2c_master_sequencer_props #(.QTR_CYC(QTR_CYC)) props_i (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .interface_on_bit_in(interface_on_bit_in),
  .interrupt_enable_bit_in(interrupt_enable_bit_in), .start_req_in(start_req_in),
  .stop_req_in(stop_req_in), .status_read_in(status_read_in),
  .data_write_in(data_write_in), .data_read_in(data_read_in),
  .control_write_in(control_write_in), .master_select_flag_out(master_select_flag_out),
  .event_flag_out(event_flag_out), .start_sent_flag_out(start_sent_flag_out),
  .byte_done_flag_out(byte_done_flag_out), .bus_busy_out(bus_busy_out),
  .irq_out(irq_out), .scl_oe_n_out(scl_oe_n_out), .sda_oe_n_out(sda_oe_n_out));

// ### sim/i2c_master_sequencer_tb.sv
/* Bench for the master sequencer: 7-bit and 10-bit master reads.
   Assumes the slave model and the checker are compiled beforehand. */
`timescale 1ns/10ps
module i2c_master_sequencer_tb;
  logic mclk_in = 0, rst_n_in = 0, on_b = 1, interrupt_enable_bit = 1, ack_en = 1;
  logic start_req = 0, stop_req = 0, sr = 0, dw = 0, dr = 0, cw = 0;
  logic [7:0] wdata = 8'h00;
  logic ms, ev, sb, bd, nack, busy, irq, sclo, scl_oe_n, sdao, sda_oe_n, sda_rel, nacked;
  logic [7:0] dreg, first_byte;
  wire scl_w = scl_oe_n;
  // Net delay gives the data line hold time after the clock falls
  wire #1 sda_w = sda_oe_n & sda_rel;
  int miscompares = 0, n_checks = 0, cyc = 0;
  always #4 mclk_in = ~mclk_in;
  i2c_master_sequencer #(.QTR_CYC(2)) i2c_master_sequencer_i (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .interface_on_bit_in(on_b),
    .interrupt_enable_bit_in(interrupt_enable_bit), .ack_enable_in(ack_en), .start_req_in(start_req),
    .stop_req_in(stop_req), .status_read_in(sr), .data_write_in(dw),
    .data_wdata_in(wdata), .data_read_in(dr), .control_write_in(cw),
    .master_select_flag_out(ms), .event_flag_out(ev), .start_sent_flag_out(sb),
    .byte_done_flag_out(bd), .addr_nack_flag_out(nack), .bus_busy_out(busy),
    .irq_out(irq), .data_register_out(dreg), .scl_in(scl_w), .scl_out(sclo),
    .scl_oe_n_out(scl_oe_n), .sda_in(sda_w), .sda_out(sdao), .sda_oe_n_out(sda_oe_n));
  i2c_slave_model i2c_slave_model_i (.scl_in(scl_w), .sda_in(sda_w),
    .sda_rel_out(sda_rel), .first_byte_out(first_byte), .nacked_out(nacked));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk8(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk(string what, logic seen, logic exp);
    chk8(what, {7'h0, seen}, {7'h0, exp});
  endtask
  task automatic step(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Kind 0 status read, 1 data write, 2 data read, 3 control write
  task automatic acc(int k, logic [7:0] d);
    wdata = d;
    {sr, dw, dr, cw} = 4'h8 >> k;
    step(1);
    {sr, dw, dr, cw} = 4'h0;
    step(1);
  endtask
  task automatic wait_ev();
    for (int i = 0; i < 400 && ev !== 1'b1; i++) step(1);
    chk("event flag", ev, 1'b1);
    chk("irq", irq, interrupt_enable_bit);
  endtask
  task automatic do_start();
    start_req = 1;
    step(2);
    chk("master select", ms, 1'b1);
    start_req = 0;
    wait_ev();
    chk("start sent", sb, 1'b1);
    chk("bus busy", busy, 1'b1);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && ms !== 1'b0; i++) step(1);
    chk("master released", ms, 1'b0);
    chk8("lines released", {6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    stop_req = 0;
    step(6);
    chk("bus free", busy, 1'b0);
  endtask
  task automatic t_reset();
    chk8("reset state", {ms, ev, sb, bd, irq, scl_oe_n, sda_oe_n}, 8'h03);
    chk8("reset data", dreg, 8'h00);
    chk8("pin levels", {6'h0, sclo, sdao}, 8'h00);
    on_b = 0;
    start_req = 1;
    step(4);
    chk("no master when off", ms, 1'b0);
    start_req = 0;
    on_b = 1;
    acc(1, 8'h12);
    chk("write in slave ignored", ms, 1'b0);
  endtask
  task automatic t_read7();
    do_start();
    step(10);
    chk("scl held", scl_oe_n, 1'b0);
    acc(1, 8'ha3);
    chk("bare write ignored", ev, 1'b1);
    acc(0, 8'h00);
    acc(1, 8'ha3);
    wait_ev();
    chk8("address on wire", first_byte, 8'ha3);
    chk("address acked", nack, 1'b0);
    acc(3, 8'h00);
    chk("bare control ignored", ev, 1'b1);
    acc(0, 8'h00);
    acc(3, 8'h00);
    wait_ev();
    chk("byte done", bd, 1'b1);
    chk8("byte 1", dreg, 8'ha4);
    chk("byte 1 acked", nacked, 1'b0);
    step(20);
    chk("scl stretched", scl_oe_n, 1'b0);
    ack_en = 0;
    acc(0, 8'h00);
    acc(2, 8'h00);
    wait_ev();
    chk8("byte 2", dreg, 8'ha7);
    chk("byte 2 not acked", nacked, 1'b1);
    stop_req = 1;
    acc(0, 8'h00);
    acc(2, 8'h00);
    wait_idle();
    ack_en = 1;
  endtask
  task automatic t_read10();
    interrupt_enable_bit = 0;
    do_start();
    acc(0, 8'h00);
    acc(1, 8'hf0);
    wait_ev();
    chk8("header on wire", first_byte, 8'hf0);
    chk("scl held after header", scl_oe_n, 1'b0);
    acc(0, 8'h00);
    acc(1, 8'h55);
    wait_ev();
    acc(0, 8'h00);
    acc(3, 8'h00);
    step(4);
    do_start();
    acc(0, 8'h00);
    acc(1, 8'hf1);
    wait_ev();
    acc(0, 8'h00);
    acc(3, 8'h00);
    wait_ev();
    chk8("10-bit byte", dreg, 8'ha4);
    stop_req = 1;
    step(1);
    stop_req = 0;
    wait_idle();
    interrupt_enable_bit = 1;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    step(10);
    rst_n_in = 1;
    step(3);
    t_reset();
    t_read7();
    t_read10();
    close_out();
  end
endmodule

// ### sim/i2c_slave_model.sv
/* Remote slave model: acks address bytes, then in read mode sends a5 xor
   byte index until the master does not acknowledge.
   Assumes open-drain lines with pull-ups resolved by the bench. */
`timescale 1ns/10ps
module i2c_slave_model (
  // Bus lines
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_rel_out,
  // Observation
  output logic [7:0]      first_byte_out,
  output logic            nacked_out
);
  int         cnt;
  int         nb;
  logic       rd;
  logic [7:0] sh;
  logic [7:0] d;
  initial begin
    {sda_rel_out, rd, nacked_out} = 3'b100;
    cnt = 0;
    nb = 0;
    first_byte_out = 8'h00;
    sh = 8'h00;
  end
  // Start or repeated Start opens a new frame
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    {cnt, nb} = '0;
    {rd, nacked_out} = 2'b00;
  end
  always @(posedge sda_in) if (scl_in === 1'b1) begin
    rd = 0;
    sda_rel_out = 1;
  end
  always @(posedge scl_in) begin
    if (cnt < 8) sh = {sh[6:0], sda_in};
    else if (rd && sda_in) begin
      rd = 0;
      nacked_out = 1;
    end
    cnt = cnt + 1;
  end
  always @(negedge scl_in) begin
    if (cnt == 8 && nb == 0) first_byte_out = sh;
    if (cnt == 9) begin
      cnt = 0;
      if (nb == 0) rd = sh[0];
      nb = nb + 1;
    end
    d = 8'ha5 ^ 8'(nb);
    if (cnt == 8) sda_rel_out = rd;
    else if (rd && nb > 0) sda_rel_out = d[7-cnt];
    else sda_rel_out = 1;
  end
endmodule
